/* File: hdl/radio_spi_pkg.sv */
// Shared constants and carriers for the radio serial configuration port
// Assumes a single 250 MHz core clock; link pins sampled into that domain
package radio_spi_pkg;
  // ----------------------------------------------------------------
  // Header and status layout
  // ----------------------------------------------------------------
  localparam int RW_BIT = 7;
  localparam int BURST_BIT = 6;
  localparam int ADDR_W = 6;
  localparam int RDY_BIT = 7;
  localparam int STATE_HI = 6;
  localparam int STATE_LO = 4;
  localparam int FILL_HI = 3;
  localparam int FILL_LO = 0;
  localparam logic [5:0] STROBE_FIRST = 6'h30;
  localparam logic [5:0] STROBE_LAST = 6'h3D;
  localparam logic [2:0] BITS_LAST = 3'h7;
  localparam logic [3:0] FILL_MAX = 4'hF;
  // ----------------------------------------------------------------
  // Register space and AHB map
  // ----------------------------------------------------------------
  localparam int REG_COUNT = 64;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RXDATA = 8'h08;
  localparam logic [7:0] REG_TXDATA = 8'h0C;
  localparam logic [5:0] REG_WINDOW = 6'h00;
  localparam int CFG_BASE_BIT = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int PD_DELAY_US = 150;
  localparam int PD_DELAY_CYCLES = PD_DELAY_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_TX, ST_FSTXON, ST_CAL, ST_SETTLE, ST_RXOVF, ST_TXUNF
  } mainState_t;

  typedef struct packed {
    logic select;
    logic sclk;
    logic sdi;
  } linkIn_t;

  typedef struct packed {
    logic valid;
    logic [5:0] addr;
    logic [7:0] data;
  } strobe_t;
endpackage

/* File: hdl/byte_fifo.sv */
// Byte FIFO between the serial port and the bus side
// Assumes writer and reader share one clock
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] next_level;
  logic push, pop;

  assign inReady = level != (AW+1)'(DEPTH);
  assign outValid = level != '0;
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_level = level + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      level <= next_level;
      if (push) mem[wrPtr] <= inData;
    end
  end
endmodule

/* File: hdl/radio_spi_config_slave.sv */
// Four-wire serial slave: header decode, register space, burst, strobes
// Assumes link pins are asynchronous to ref_clk and much slower than it
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// [R1] Slave on four-wire link for register access and buffered data.
// [R2] Every byte shifts most significant bit first, both directions.
// [R3] Header holds direction bit, burst bit, then six address bits.
// [R4] Host keeps select low for the whole transfer.
// [R5] Select released mid-header or mid-byte abandons the transfer.
// [R6] Host waits for serial out low before shifting the header.
// [R7] Select low while oscillator runs drives serial out low immediately.
// [R8] Host not watching ready waits the power-down select-to-clock delay.
// [R9] Chip reset loads every configuration register with its default.
// [R10] Host rewrites non-default registers after each reset.
// [R11] Host keeps serial clock within single and burst rate limits.
// [R12] Host inserts idle gaps to run the clock at top rate.
// [R13] Status byte shifts out during header and written data bytes.
// [R14] Burst increments the internal address after every byte.
// [R15] Burst is all reads or all writes, ended by select release.
// [R16] Addresses 0x30-0x3D: burst bit reads status, clear bit strobes.
// [R17] Sample input on rising clock, update output after falling edge.
module radio_spi_config_slave
  import radio_spi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic select_n_pin,
  input wire logic sclkPin,
  input wire logic sdiPin,
  output logic sdoPin,
  output logic sdoEnable,
  input wire logic oscillatorRunning,
  input wire logic sleepState,
  input wire logic oscillator_off_state,
  input wire mainState_t mainState,
  output strobe_t cmdStrobe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  linkIn_t pinMeta, pinSync, pinLast;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinMeta <= '{select: 1'b0, sclk: 1'b0, sdi: 1'b0};
      pinSync <= '{select: 1'b0, sclk: 1'b0, sdi: 1'b0};
      pinLast <= '{select: 1'b0, sclk: 1'b0, sdi: 1'b0};
    end else begin
      pinMeta <= '{select: ~select_n_pin, sclk: sclkPin, sdi: sdiPin};
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end
  logic sclkRise, sclkFall, selActive, selStart;
  assign selActive = pinSync.select;
  assign selStart = pinSync.select && !pinLast.select;
  assign sclkRise = selActive && pinSync.sclk && !pinLast.sclk; // [R17]
  assign sclkFall = selActive && !pinSync.sclk && pinLast.sclk; // [R17]

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_HEADER, PH_DATA, PH_DONE} phase_t;
  phase_t phase, next_phase;
  logic [7:0] shiftIn, next_shiftIn, shiftOut, next_shiftOut;
  logic [2:0] bitCnt, next_bitCnt;
  logic [5:0] addr, next_addr;
  logic isRead, next_isRead, isBurst, next_isBurst;
  logic [7:0] regs [REG_COUNT];
  logic regWrite;
  logic [7:0] regWdata;
  logic [5:0] regWaddr;
  strobe_t next_cmdStrobe;
  logic oscReady;
  logic [3:0] txFree, rxAvail;
  logic [$clog2(FIFO_DEPTH):0] rxLevel, txLevel;
  logic rxInValid, rxInReady, txOutValid, txOutReady;
  logic [7:0] txOutData;

  function automatic logic isStrobeAddr(input logic [5:0] a);
    return a >= STROBE_FIRST && a <= STROBE_LAST;
  endfunction
  function automatic logic [3:0] clampFill(input logic [4:0] n);
    return n > 5'(FILL_MAX) ? FILL_MAX : n[3:0];
  endfunction
  assign oscReady = oscillatorRunning && !sleepState && !oscillator_off_state;
  assign rxAvail = clampFill(5'(txLevel));
  assign txFree = clampFill(5'(FIFO_DEPTH) - 5'(rxLevel));

  function automatic logic [7:0] statusByte(input logic rd);
    logic [7:0] s;
    s = '0;
    s[RDY_BIT] = !oscReady; // [R13]
    s[STATE_HI:STATE_LO] = mainState; // [R13]
    s[FILL_HI:FILL_LO] = rd ? rxAvail : txFree; // [R13]
    return s;
  endfunction
  function automatic logic [7:0] readByte(input logic [5:0] a);
    return a == REG_WINDOW ? txOutData : regs[a];
  endfunction

  logic [7:0] rxByte;
  assign rxByte = {shiftIn[6:0], pinSync.sdi};

  always_comb begin
    next_phase = phase;
    next_shiftIn = shiftIn;
    next_shiftOut = shiftOut;
    next_bitCnt = bitCnt;
    next_addr = addr;
    next_isRead = isRead;
    next_isBurst = isBurst;
    next_cmdStrobe = '0;
    regWrite = 1'b0;
    regWaddr = addr;
    regWdata = rxByte;
    rxInValid = 1'b0;
    txOutReady = 1'b0;
    if (!selActive) begin
      next_phase = PH_HEADER; // [R5]
      next_bitCnt = '0; // [R5]
      next_shiftOut = '0;
      next_shiftOut[RDY_BIT] = 1'b1; // Reads as not ready until the status loads [R7]
    end else if (selStart) begin
      next_phase = PH_HEADER;
      next_bitCnt = '0;
      next_shiftOut = statusByte(1'b0); // [R13]
    end else if (sclkRise) begin
      next_shiftIn = rxByte; // [R2]
      next_bitCnt = bitCnt + 3'h1;
      if (bitCnt == BITS_LAST) begin
        unique case (phase)
          PH_HEADER: begin
            next_isRead = rxByte[RW_BIT]; // [R3]
            next_isBurst = rxByte[BURST_BIT]; // [R3]
            next_addr = rxByte[ADDR_W-1:0]; // [R3] [R14]
            if (isStrobeAddr(rxByte[ADDR_W-1:0]) && !rxByte[BURST_BIT]) begin
              next_cmdStrobe = '{valid: 1'b1, addr: rxByte[5:0], data: 8'h00}; // [R16]
              next_phase = PH_DONE;
            end else begin
              next_phase = PH_DATA;
            end
          end
          PH_DATA: begin
            if (!isRead) begin
              regWrite = 1'b1; // [R1]
              rxInValid = addr == REG_WINDOW;
            end else if (addr == REG_WINDOW) begin
              txOutReady = 1'b1;
            end
            // Status space forbids burst, so only one byte there
            if (isBurst && !isStrobeAddr(addr)) begin
              next_addr = addr + 6'h1; // [R14] [R15]
            end else begin
              next_phase = PH_DONE;
            end
          end
          default: next_phase = PH_DONE;
        endcase
      end
    end else if (sclkFall && bitCnt == '0) begin
      if (phase == PH_DATA && isRead) begin
        next_shiftOut = readByte(addr); // [R1]
      end else begin
        next_shiftOut = statusByte(isRead); // [R13]
      end
    end else if (sclkFall) begin
      next_shiftOut = {shiftOut[6:0], 1'b0}; // [R2] [R17]
      if (phase == PH_HEADER && bitCnt == 3'h1) begin
        next_shiftOut[FILL_HI+1:FILL_LO+1] = shiftIn[0] ? rxAvail : txFree; // [R13]
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase <= PH_HEADER;
      shiftIn <= '0;
      shiftOut <= '0;
      bitCnt <= '0;
      addr <= '0;
      isRead <= 1'b0;
      isBurst <= 1'b0;
      cmdStrobe <= '0;
    end else begin
      phase <= next_phase;
      shiftIn <= next_shiftIn;
      shiftOut <= next_shiftOut;
      bitCnt <= next_bitCnt;
      addr <= next_addr;
      isRead <= next_isRead;
      isBurst <= next_isBurst;
      cmdStrobe <= next_cmdStrobe;
    end
  end

  // First status bit is ready flag; low at select when oscillator runs outside sleep and off states
  assign sdoPin = shiftOut[7]; // [R7] [R13]
  assign sdoEnable = selActive;

  // ----------------------------------------------------------------
  // Configuration registers and data FIFOs
  // ----------------------------------------------------------------
  logic [31:0] next_hrdata;
  logic [7:0] busAddr;
  logic busWrite, busRead, dataPhaseWr;
  logic [7:0] busAddrQ;
  logic txInReady, rxOutValid, rxOutReady;
  logic [7:0] rxOutData;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT; i++) regs[i] <= REG_RESET_VALUE; // [R9]
    end else if (regWrite && !isStrobeAddr(regWaddr)) begin
      regs[regWaddr] <= regWdata;
    end else if (dataPhaseWr && busAddrQ == REG_CTRL) begin
      regs[hwdata[CFG_BASE_BIT+5:CFG_BASE_BIT]] <= hwdata[7:0];
    end
  end
  // Bytes written over the link flow toward the bus reader
  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rxFifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(rxInValid),
    .inReady(rxInReady),
    .inData(regWdata),
    .outValid(rxOutValid),
    .outReady(rxOutReady),
    .outData(rxOutData),
    .level(rxLevel)
  );
  // Bytes from the bus wait here for link reads
  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) txFifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(dataPhaseWr && busAddrQ == REG_TXDATA),
    .inReady(txInReady),
    .inData(hwdata[7:0]),
    .outValid(txOutValid),
    .outReady(txOutReady),
    .outData(txOutData),
    .level(txLevel)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states except a full transmit buffer
  // ----------------------------------------------------------------
  assign busAddr = haddr[7:0];
  assign busWrite = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
  assign busRead = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  logic wrPending, next_wrPending;
  assign dataPhaseWr = wrPending && hreadyout;
  // Stall on a full buffer pushes back on the bus master
  assign hreadyout = !(wrPending && busAddrQ == REG_TXDATA && !txInReady);
  assign hresp = 1'b0;
  assign rxOutReady = busRead && busAddr == REG_RXDATA;

  always_comb begin
    next_hrdata = '0;
    next_wrPending = busWrite || (wrPending && !hreadyout);
    if (busRead) begin
      unique case (busAddr)
        REG_STATUS: next_hrdata = {16'h0000, statusByte(1'b0), 7'h00, rxOutValid};
        REG_RXDATA: next_hrdata = {24'h000000, rxOutData};
        REG_CTRL: next_hrdata = {24'h000000, cmdStrobe.valid, 1'b0, cmdStrobe.addr};
        default: next_hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= '0;
      wrPending <= 1'b0;
      busAddrQ <= '0;
    end else begin
      hrdata <= next_hrdata;
      wrPending <= next_wrPending;
      if (hready) busAddrQ <= busAddr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_headerByte;
    sclkRise && bitCnt == BITS_LAST && phase == PH_HEADER;
  endsequence

  property p_sdoReady;
    @(posedge ref_clk) disable iff (reset)
      selStart && oscReady |=> !sdoPin;
  endproperty
  a_sdoReady: assert property (p_sdoReady) else $error("ready low missing"); // [R7]
  property p_abandon;
    @(posedge ref_clk) disable iff (reset)
      !selActive |=> bitCnt == '0 && phase == PH_HEADER;
  endproperty
  a_abandon: assert property (p_abandon) else $error("transfer not abandoned"); // [R5]
  property p_strobe;
    @(posedge ref_clk) disable iff (reset)
      s_headerByte ##0 (isStrobeAddr(rxByte[5:0]) && !rxByte[BURST_BIT]) |=> cmdStrobe.valid;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not issued"); // [R16]
  property p_burstInc;
    @(posedge ref_clk) disable iff (reset)
      sclkRise && bitCnt == BITS_LAST && phase == PH_DATA && isBurst && !isStrobeAddr(addr)
      |=> addr == $past(addr) + 6'h1;
  endproperty
  a_burstInc: assert property (p_burstInc) else $error("burst address stuck"); // [R14]
  property p_header;
    @(posedge ref_clk) disable iff (reset)
      s_headerByte |=> isRead == $past(rxByte[RW_BIT]) && isBurst == $past(rxByte[BURST_BIT]);
  endproperty
  a_header: assert property (p_header) else $error("header decode wrong"); // [R3]
  property p_msbFirst;
    @(posedge ref_clk) disable iff (reset)
      sclkFall && bitCnt != '0 |=> sdoPin == $past(shiftOut[6]);
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("shift order wrong"); // [R2] [R17]
  property p_status;
    @(posedge ref_clk) disable iff (reset)
      selStart |=> shiftOut[STATE_HI:STATE_LO] == $past(mainState);
  endproperty
  a_status: assert property (p_status) else $error("status state wrong"); // [R13]
  property p_reset;
    @(posedge ref_clk) reset |=> regs[0] == REG_RESET_VALUE && regs[63] == REG_RESET_VALUE;
  endproperty
  a_reset: assert property (p_reset) else $error("reset default missing"); // [R9]
endmodule

/* File: bench/spi_host.sv */
// Host model driving the four-wire serial link as master
// Assumes the slave samples link pins with ref_clk, 12 cycles per link clock
`timescale 1ns/1ns
module spi_host (
  input wire logic ref_clk,
  input wire logic sdoPin,
  input wire logic sdoEnable,
  output logic select_n_pin,
  output logic sclkPin,
  output logic sdiPin
);
  // ----------------------------------------------------------------
  // Line model and frame tasks
  // ----------------------------------------------------------------
  logic lastSdo = 1'b0;
  logic sdoWire;
  // A released line must not look like a valid bit
  assign sdoWire = sdoEnable ? sdoPin : ~lastSdo;
  always @(posedge ref_clk) begin
    if (sdoEnable === 1'b1) lastSdo <= sdoPin;
  end
  initial begin
    select_n_pin = 1'b1;
    sclkPin = 1'b0; // Clock stands still between frames
    sdiPin = 1'b0;
  end
  task automatic open_frame(output logic ready);
    int n;
    @(posedge ref_clk);
    select_n_pin <= 1'b0;
    // Only a driven low line counts; a floating line proves nothing
    for (n = 0; n < 40 && !(sdoEnable === 1'b1 && sdoWire === 1'b0); n++) begin
      @(negedge ref_clk);
    end
    ready = (sdoEnable === 1'b1 && sdoWire === 1'b0);
  endtask
  // 48 ns period with 24 ns setup stays inside every rate limit
  task automatic xfer(input logic [7:0] tx, input int bits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - bits; i--) begin
      sdiPin <= tx[i];
      repeat (6) @(posedge ref_clk);
      sclkPin <= 1'b1;
      rx[i] = sdoWire;
      repeat (6) @(posedge ref_clk);
      sclkPin <= 1'b0;
    end
  endtask
  task automatic close_frame;
    repeat (8) @(posedge ref_clk);
    select_n_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the serial configuration slave
// Assumes one 250 MHz clock; host model drives the link, tasks drive AHB
`timescale 1ns/1ns
module testbench;
  import radio_spi_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, model and checks
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic oscillatorRunning = 1'b1;
  logic sleepState = 1'b0;
  logic oscillator_off_state = 1'b0;
  mainState_t mainState = ST_IDLE;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic select_n_pin, sclkPin, sdiPin, sdoPin, sdoEnable, hreadyout, hresp;
  logic [31:0] hrdata;
  strobe_t cmdStrobe;
  int errors = 0;
  int total_checks = 0;
  int strobes = 0;
  int seed = 54173;
  logic [5:0] strobeAddr;
  logic [7:0] dat [0:8];
  logic [7:0] stat;

  always #2 ref_clk = ~ref_clk;

  radio_spi_config_slave radio_spi_config_slave_i (.ref_clk, .reset, .select_n_pin,
    .sclkPin, .sdiPin, .sdoPin, .sdoEnable, .oscillatorRunning, .sleepState,
    .oscillator_off_state, .mainState, .cmdStrobe, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  spi_host spi_host_i (.ref_clk, .sdoPin, .sdoEnable, .select_n_pin, .sclkPin, .sdiPin);

  always @(posedge ref_clk) begin
    if (cmdStrobe.valid === 1'b1) begin
      strobes++;
      strobeAddr = cmdStrobe.addr;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [7:0] status_of(input logic [3:0] fill);
    return {1'b0, mainState, fill};
  endfunction

  task automatic wait_ready;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    hwrite <= wr;
    haddr <= a;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask

  // Header, then n bytes from dat; reads land back in dat
  task automatic link(input logic [7:0] hdr, input int n, input int cut);
    logic rdy;
    logic [7:0] rx;
    spi_host_i.open_frame(rdy);
    check(rdy, 1'b1);
    check(sdoEnable, 1'b1);
    spi_host_i.xfer(hdr, 8, stat);
    for (int i = 0; i < n; i++) begin
      spi_host_i.xfer(dat[i], i == n - 1 ? cut : 8, rx);
      if (hdr[RW_BIT]) dat[i] = rx;
    end
    spi_host_i.close_frame();
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    close_out();
  end

  initial begin
    logic [31:0] rd;
    logic [7:0] d;
    logic [7:0] v [0:8];
    logic rdy;
    int a, k, n0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    for (k = 0; k < 3; k++) begin
      oscillatorRunning <= k != 0;
      sleepState <= k == 1;
      oscillator_off_state <= k == 2;
      spi_host_i.open_frame(rdy);
      check(rdy, 1'b0);
      spi_host_i.close_frame();
    end
    oscillatorRunning <= 1'b1;
    sleepState <= 1'b0;
    oscillator_off_state <= 1'b0;
    link(8'hAE, 1, 8);
    check(dat[0], REG_RESET_VALUE);
    for (k = 0; k < 6; k++) begin
      a = ($random(seed) & 32'h1F) + 1;
      d = 8'($random(seed));
      mainState <= mainState_t'($random(seed) & 32'h7);
      dat[0] = d;
      if (k[0]) ahb(1'b1, {24'h0, REG_CTRL}, {18'h0, a[5:0], d}, rd);
      else begin
        link({2'b00, a[5:0]}, 1, 8);
        check(stat, status_of(4'h8));
      end
      link({2'b10, a[5:0]}, 1, 8);
      check(stat, status_of(4'h0));
      check(dat[0], d);
    end
    // Half a data byte, then select released
    dat[0] = ~d;
    link({2'b00, a[5:0]}, 1, 4);
    link({2'b10, a[5:0]}, 1, 8);
    check(dat[0], d);
    for (k = 0; k < 4; k++) begin
      v[k] = 8'($random(seed));
      dat[k] = v[k];
    end
    link(8'h48, 4, 8);
    link(8'hC8, 4, 8);
    for (k = 0; k < 4; k++) check(dat[k], v[k]);
    link(8'h8B, 1, 8);
    check(dat[0], v[3]);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    link(8'h8B, 1, 8);
    check(dat[0], REG_RESET_VALUE);
    dat[0] = v[3];
    link(8'h0B, 1, 8);
    link(8'h8B, 1, 8);
    check(dat[0], v[3]);
    for (a = 6'h2F; a <= 6'h3E; a++) begin
      n0 = strobes;
      link({2'b00, a[5:0]}, 0, 8);
      check(strobes - n0, a >= STROBE_FIRST && a <= STROBE_LAST);
      if (strobes != n0) check(strobeAddr, a[5:0]);
    end
    ahb(1'b1, {24'h0, REG_CTRL}, 32'h35A5, rd);
    n0 = strobes;
    link(8'hF5, 1, 8);
    check(dat[0], 8'hA5);
    check(strobes, n0);
    for (k = 0; k < 9; k++) v[k] = 8'($random(seed));
    for (k = 0; k < 8; k++) ahb(1'b1, {24'h0, REG_TXDATA}, {24'h0, v[k]}, rd);
    fork
      ahb(1'b1, {24'h0, REG_TXDATA}, {24'h0, v[8]}, rd);
      begin
        repeat (20) @(posedge ref_clk);
        check(hreadyout, 1'b0);
        link(8'h80, 1, 8);
        check(stat, status_of(4'h8));
        check(dat[0], v[0]);
      end
    join
    for (k = 1; k < 9; k++) begin
      link(8'h80, 1, 8);
      check(stat, status_of(4'(9 - k)));
      check(dat[0], v[k]);
    end
    for (k = 0; k < 3; k++) begin
      dat[0] = v[k];
      link(8'h00, 1, 8);
      check(stat, status_of(4'(8 - k)));
    end
    for (k = 0; k < 3; k++) begin
      ahb(1'b0, {24'h0, REG_RXDATA}, 32'h0, rd);
      check(rd[7:0], v[k]);
    end
    ahb(1'b0, {24'h0, REG_STATUS}, 32'h0, rd);
    check(rd, {16'h0000, status_of(4'h8), 8'h00});
    ahb(1'b0, 32'h40, 32'h0, rd);
    check(rd, 32'h0);
    close_out();
  end
endmodule
